// >>> core/sse_pkg.sv
// Shared constants, carriers and helpers of the byte-wide serial shift engine.
package sse_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int SSE_BYTE_W = 8;
   localparam logic [2:0] SSE_IDX_FIRST = 3'h0;
   localparam logic [2:0] SSE_IDX_LAST = 3'h7;
   localparam logic [2:0] SSE_IDX_STEP = 3'h1;
   localparam logic [4:0] SSE_EDGE_NONE = 5'h00;
   localparam logic [4:0] SSE_EDGE_STEP = 5'h01;
   localparam logic [4:0] SSE_EDGE_LAST = 5'h10;
   localparam logic [15:0] SSE_HALF_DIV_DEFAULT = 16'h0004;
   localparam logic [15:0] SSE_CNT_STEP = 16'h0001;
   localparam logic [7:0] SSE_BYTE_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic rx_fault_irq_enable;
      logic tx_irq_enable;
      logic controller_select_bit;
      logic cpol;
      logic cpha;
      logic select_output_enable;
      logic lsb_first_enable;
   } sse_ctrl_s;

   localparam sse_ctrl_s SSE_CTRL_RESET = '0;

   typedef struct packed {
      logic rx_full_flag;
      logic mode_fault_flag;
      logic tx_buffer_empty_flag;
   } sse_status_s;

   typedef struct packed {
      logic o;
      logic oe;
   } sse_pin_s;

   typedef enum logic [1:0] {
      SSE_IDLE,
      SSE_RUN,
      SSE_TRAIL
   } sse_phase_e;

   ////////////////////////////////////////////////////////////////////////////
   // Picks the bit that goes on the line at position idx of the byte.
   function automatic logic sse_bit_at(input logic [7:0] b, input logic [2:0] idx, input logic lsb);
      logic [2:0] pos;
      pos = lsb ? idx : (SSE_IDX_LAST - idx);
      return b[pos];
   endfunction

   // Shifts one received bit into the assembly byte in line order.
   function automatic logic [7:0] sse_shift_in(input logic [7:0] b, input logic d, input logic lsb);
      return lsb ? {d, b[7:1]} : {b[6:0], d};
   endfunction

endpackage

// >>> core/sse_sync.sv
// Two-flop synchroniser for a group of levels entering the core clock domain.
`timescale 1ns/1ps
module sse_sync
   import sse_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sse_sync_s;

   sse_sync_s s;
   sse_sync_s next_s;

   always_comb begin
      next_s = s;
      next_s.first = async_in;
      next_s.second = s.first;
   end

   // Resets to all ones so that a low-active select reads idle after reset.
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         s <= '1;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.second;

endmodule

// >>> core/sse_link_periph.sv
// Peripheral-side bit engine clocked by the remote controller's serial clock.
`timescale 1ns/1ps
module sse_link_periph
   import sse_pkg::*;
(
   input wire logic sample_clk_in,
   input wire logic reset_in,
   input wire logic select_n_in,
   input wire logic mosi_in,
   input wire logic cpha_in,
   input wire logic lsb_first_enable_in,
   input wire logic [7:0] tx_byte_in,
   output logic [7:0] rx_byte_out,
   output logic done_toggle_out,
   output logic miso_bit_out
);

   typedef struct packed {
      logic [7:0] rx_sh;
      logic [2:0] rx_cnt;
   } sse_frame_s;

   typedef struct packed {
      logic [7:0] rx_byte;
      logic done_toggle;
   } sse_hold_s;

   sse_frame_s f;
   sse_frame_s next_f;
   sse_hold_s h;
   sse_hold_s next_h;
   logic [2:0] launch_cnt;
   logic [2:0] out_idx;
   logic frame_reset;

   // A high select ends the frame without needing another clock edge.
   assign frame_reset = reset_in | select_n_in;

   always_comb begin
      next_f = f;
      next_h = h;
      next_f.rx_sh = sse_shift_in(f.rx_sh, mosi_in, lsb_first_enable_in);
      next_f.rx_cnt = f.rx_cnt + SSE_IDX_STEP;
      if (f.rx_cnt == SSE_IDX_LAST) begin
         next_h.rx_byte = next_f.rx_sh;
         next_h.done_toggle = ~h.done_toggle;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sample on one edge.
   always_ff @(posedge sample_clk_in or posedge frame_reset) begin
      if (frame_reset) begin
         f <= '0;
      end else begin
         f <= next_f;
      end
   end

   // The held byte and toggle survive the end of a frame.
   always_ff @(posedge sample_clk_in or posedge reset_in) begin
      if (reset_in) begin
         h <= '0;
      end else begin
         h <= next_h;
      end
   end

   always_ff @(negedge sample_clk_in or posedge frame_reset) begin
      if (frame_reset) begin
         launch_cnt <= SSE_IDX_FIRST;
      end else begin
         launch_cnt <= launch_cnt + SSE_IDX_STEP;
      end
   end

   assign out_idx = cpha_in ? (launch_cnt - SSE_IDX_STEP) : launch_cnt;

   assign miso_bit_out = sse_bit_at(tx_byte_in, out_idx, lsb_first_enable_in);
   assign rx_byte_out = h.rx_byte;
   assign done_toggle_out = h.done_toggle;

endmodule

// >>> core/sse_engine.sv
// Byte-wide serial shift engine with double buffering, four clock formats and mode fault.
//
// Notes on behaviour
// - Write when empty starts controller transfer.
// - Sample one edge, shift half later.
// - Eight clock periods shift a byte.
// - Completed byte goes to receive buffer.
// - Queued byte starts next transfer immediately.
// - MSB first unless lsb-first set.
// - One holding byte each direction.
// - Overrun drops new byte silently.
// - Polarity inverts clock; phase picks relation.
// - Phase one select leads half period.
// - Phase zero select trails half period.
// - Phase one: first edge launches bit.
// - Phase zero: bit present on select.
// - Phase one bit timing from edges.
// - Phase zero bit timing from select.
// - Interrupt request from flags and enables.
// - Select input faults when configured.
// - Fault drops controller mode and drivers.
// - Fault flag clears: status read, control write.
// - Data write needs prior empty status read.
// - Full flag clears: status read, data read.
`timescale 1ns/1ps
module sse_engine
   import sse_pkg::*;
#(
   parameter logic [15:0] HALF_DIV = SSE_HALF_DIV_DEFAULT
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic ctrl1_write_in,
   input wire sse_ctrl_s ctrl1_in,
   input wire logic fault_detect_enable_in,
   input wire logic status_read_in,
   output sse_status_s status_out,
   input wire logic data_write_in,
   input wire logic [7:0] data_in,
   input wire logic data_read_in,
   output logic [7:0] data_out,
   output sse_ctrl_s ctrl_out,
   output logic irq_out,
   output logic busy_out,
   input wire logic serial_clock_pin_in,
   output sse_pin_s serial_clock_pin_out,
   input wire logic mosi_pin_in,
   output sse_pin_s mosi_pin_out,
   input wire logic miso_pin_in,
   output sse_pin_s miso_pin_out,
   input wire logic select_pin_n_in,
   output sse_pin_s select_pin_n_out
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      sse_ctrl_s ctrl;
      logic rx_full_flag;
      logic mode_fault_flag;
      logic tx_buffer_empty_flag;
      logic tx_armed;
      logic rx_armed;
      logic mode_fault_flag_armed;
      logic [7:0] tx_buf;
      logic [7:0] rx_buf;
      logic [7:0] tx_sh;
      logic [7:0] rx_sh;
      sse_phase_e phase;
      logic [15:0] hp_cnt;
      logic [4:0] edge_cnt;
      logic [2:0] tx_idx;
      logic mosi_bit;
      logic sck_lvl;
      logic ss_lvl;
      logic [7:0] periph_tx;
      logic periph_loaded;
      logic done_seen;
   } sse_state_s;

   sse_state_s s;
   sse_state_s next_s;

   logic [2:0] sync_raw;
   logic [2:0] sync_q;
   logic select_n_sync;
   logic miso_sync;
   logic done_sync;
   logic link_clk;
   logic [7:0] link_rx_byte;
   logic link_done_toggle;
   logic link_miso_bit;
   logic is_controller;
   logic fault_now;
   logic link_done;
   logic [4:0] edge_next;
   logic do_sample;

   ////////////////////////////////////////////////////////////////////////////
   // The select and MISO pins and the link completion toggle are synchronised here.
   // The toggle crosses inverted so that the all-ones synchroniser reset reads as no completion.
   assign sync_raw = {select_pin_n_in, miso_pin_in, ~link_done_toggle};

   sse_sync #(
      .WIDTH(3)
   ) u_sync (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .async_in(sync_raw),
      .sync_out(sync_q)
   );

   assign select_n_sync = sync_q[2];
   assign miso_sync = sync_q[1];
   assign done_sync = ~sync_q[0];

   ////////////////////////////////////////////////////////////////////////////
   // Polarity and phase fold into one sample edge.
   // The control bits are quasi-static; changing them inside a frame corrupts that frame.
   assign link_clk = serial_clock_pin_in ^ s.ctrl.cpol ^ s.ctrl.cpha;

   // The byte offered to the remote controller is reloaded from tx_buf as soon as none is held for the link,
   // after reset or after the link reports completion, so a data write inside a frame can change it mid-frame.
   sse_link_periph u_link (
      .sample_clk_in(link_clk),
      .reset_in(reset_in),
      .select_n_in(select_pin_n_in),
      .mosi_in(mosi_pin_in),
      .cpha_in(s.ctrl.cpha),
      .lsb_first_enable_in(s.ctrl.lsb_first_enable),
      .tx_byte_in(s.periph_tx),
      .rx_byte_out(link_rx_byte),
      .done_toggle_out(link_done_toggle),
      .miso_bit_out(link_miso_bit)
   );

   ////////////////////////////////////////////////////////////////////////////
   assign is_controller = s.ctrl.controller_select_bit;

   assign fault_now = is_controller & fault_detect_enable_in & ~s.ctrl.select_output_enable & ~select_n_sync;

   assign link_done = done_sync != s.done_seen;
   assign edge_next = s.edge_cnt + SSE_EDGE_STEP;

   assign do_sample = edge_next[0] ^ s.ctrl.cpha;

   always_comb begin
      next_s = s;
      next_s.done_seen = done_sync;

      // Status reads arm the clearing sequences of the flags seen set.
      if (status_read_in) begin
         next_s.tx_armed = s.tx_buffer_empty_flag;
         next_s.rx_armed = s.rx_full_flag;
         next_s.mode_fault_flag_armed = s.mode_fault_flag;
      end

      if (data_read_in && s.rx_armed) begin
         next_s.rx_full_flag = 1'b0;
         next_s.rx_armed = 1'b0;
      end

      if (data_write_in && s.tx_armed && s.tx_buffer_empty_flag) begin
         next_s.tx_buf = data_in;
         next_s.tx_buffer_empty_flag = 1'b0;
         next_s.tx_armed = 1'b0;
      end

      if (ctrl1_write_in) begin
         next_s.ctrl = ctrl1_in;
         if (s.mode_fault_flag_armed) begin
            next_s.mode_fault_flag = 1'b0;
            next_s.mode_fault_flag_armed = 1'b0;
         end
      end

      /////////////////////////////////////////////////////////////////////////
      // Controller engine. One half period of HALF_DIV core cycles per clock edge.
      case (s.phase)
         SSE_IDLE: begin
            next_s.sck_lvl = s.ctrl.cpol;
            next_s.ss_lvl = 1'b1;
            if (is_controller && !s.tx_buffer_empty_flag) begin
               next_s.tx_sh = s.tx_buf;
               next_s.tx_buffer_empty_flag = 1'b1;
               next_s.phase = SSE_RUN;
               next_s.hp_cnt = HALF_DIV - SSE_CNT_STEP;
               next_s.edge_cnt = SSE_EDGE_NONE;
               next_s.tx_idx = SSE_IDX_FIRST;
               next_s.ss_lvl = 1'b0;
               if (!s.ctrl.cpha) begin
                  next_s.mosi_bit = sse_bit_at(s.tx_buf, SSE_IDX_FIRST, s.ctrl.lsb_first_enable);
                  next_s.tx_idx = SSE_IDX_STEP;
               end
            end
         end
         SSE_RUN: begin
            if (!is_controller) begin
               next_s.phase = SSE_IDLE;
            end else if (s.hp_cnt != '0) begin
               next_s.hp_cnt = s.hp_cnt - SSE_CNT_STEP;
            end else begin
               next_s.hp_cnt = HALF_DIV - SSE_CNT_STEP;
               next_s.edge_cnt = edge_next;
               next_s.sck_lvl = ~s.sck_lvl;
               if (do_sample) begin
                  next_s.rx_sh = sse_shift_in(s.rx_sh, miso_sync, s.ctrl.lsb_first_enable);
               end else if (edge_next != SSE_EDGE_LAST) begin
                  next_s.mosi_bit = sse_bit_at(s.tx_sh, s.tx_idx, s.ctrl.lsb_first_enable);
                  next_s.tx_idx = s.tx_idx + SSE_IDX_STEP;
               end
               if (edge_next == SSE_EDGE_LAST) begin
                  next_s.phase = SSE_TRAIL;
               end
            end
         end
         SSE_TRAIL: begin
            if (!is_controller) begin
               next_s.phase = SSE_IDLE;
            end else if (s.hp_cnt != '0) begin
               next_s.hp_cnt = s.hp_cnt - SSE_CNT_STEP;
            end else begin
               next_s.ss_lvl = 1'b1;
               next_s.phase = SSE_IDLE;
               if (!s.rx_full_flag || next_s.rx_full_flag == 1'b0 && s.rx_armed && data_read_in) begin
                  next_s.rx_buf = s.rx_sh;
                  next_s.rx_full_flag = 1'b1;
               end
            end
         end
         default: begin
            next_s.phase = SSE_IDLE;
         end
      endcase

      /////////////////////////////////////////////////////////////////////////
      // Peripheral path. The shifter byte is handed to the link domain whenever periph_loaded is clear, which can be inside a frame.
      if (!is_controller) begin
         if (!s.periph_loaded && !s.tx_buffer_empty_flag) begin
            next_s.periph_tx = s.tx_buf;
            next_s.periph_loaded = 1'b1;
            next_s.tx_buffer_empty_flag = 1'b1;
         end
      end
      if (link_done) begin
         next_s.periph_loaded = 1'b0;
         if (!is_controller && (!s.rx_full_flag || (s.rx_armed && data_read_in))) begin
            next_s.rx_buf = link_rx_byte;
            next_s.rx_full_flag = 1'b1;
         end
      end

      /////////////////////////////////////////////////////////////////////////
      // Fault leaves controller mode.
      // A fault in the cycle of a clearing write still sets the flag.
      if (fault_now) begin
         next_s.mode_fault_flag = 1'b1;
         next_s.ctrl.controller_select_bit = 1'b0;
         next_s.phase = SSE_IDLE;
         next_s.ss_lvl = 1'b1;
         next_s.sck_lvl = s.ctrl.cpol;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         s.ctrl <= SSE_CTRL_RESET;
         s.rx_full_flag <= 1'b0;
         s.mode_fault_flag <= 1'b0;
         s.tx_buffer_empty_flag <= 1'b1;
         s.tx_armed <= 1'b0;
         s.rx_armed <= 1'b0;
         s.mode_fault_flag_armed <= 1'b0;
         s.tx_buf <= SSE_BYTE_RESET;
         s.rx_buf <= SSE_BYTE_RESET;
         s.tx_sh <= SSE_BYTE_RESET;
         s.rx_sh <= SSE_BYTE_RESET;
         s.phase <= SSE_IDLE;
         s.hp_cnt <= '0;
         s.edge_cnt <= SSE_EDGE_NONE;
         s.tx_idx <= SSE_IDX_FIRST;
         s.mosi_bit <= 1'b0;
         s.sck_lvl <= 1'b0;
         s.ss_lvl <= 1'b1;
         s.periph_tx <= SSE_BYTE_RESET;
         s.periph_loaded <= 1'b0;
         s.done_seen <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign status_out.rx_full_flag = s.rx_full_flag;
   assign status_out.mode_fault_flag = s.mode_fault_flag;
   assign status_out.tx_buffer_empty_flag = s.tx_buffer_empty_flag;
   assign data_out = s.rx_buf;
   assign ctrl_out = s.ctrl;
   assign busy_out = s.phase != SSE_IDLE;

   assign irq_out = ((s.rx_full_flag | s.mode_fault_flag) & s.ctrl.rx_fault_irq_enable)
                  | (s.tx_buffer_empty_flag & s.ctrl.tx_irq_enable);

   assign serial_clock_pin_out.o = s.sck_lvl;
   assign serial_clock_pin_out.oe = is_controller;
   assign mosi_pin_out.o = s.mosi_bit;
   assign mosi_pin_out.oe = is_controller;

   assign miso_pin_out.o = link_miso_bit;
   assign miso_pin_out.oe = ~is_controller & ~select_n_sync & ~s.mode_fault_flag;

   assign select_pin_n_out.o = s.ss_lvl;
   assign select_pin_n_out.oe = is_controller & fault_detect_enable_in & s.ctrl.select_output_enable;

endmodule

// >>> test/sse_engine_properties.sv
// Port-level temporal checks of the serial shift engine, bound into every engine instance.
`timescale 1ns/1ps
module sse_engine_properties
   import sse_pkg::*;
#(
   parameter logic [15:0] HALF_DIV = SSE_HALF_DIV_DEFAULT
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic ctrl1_write_in,
   input wire logic fault_detect_enable_in,
   input wire logic data_write_in,
   input wire logic data_read_in,
   input wire sse_status_s status_out,
   input wire sse_ctrl_s ctrl_out,
   input wire logic irq_out,
   input wire logic busy_out,
   input wire sse_pin_s serial_clock_pin_out,
   input wire sse_pin_s mosi_pin_out,
   input wire sse_pin_s select_pin_n_out
);
   logic [4:0] edge_cnt;
   logic sck_prev;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // Counts serial clock toggles while our own select is low, so a short or long frame shows at its end.
   always_ff @(posedge core_clk_in) begin
      sck_prev <= serial_clock_pin_out.o;
      if (reset_in || select_pin_n_out.o)
         edge_cnt <= 5'h00;
      else if (serial_clock_pin_out.o != sck_prev)
         edge_cnt <= edge_cnt + 5'h01;
   end
   sequence s_frame_open;
      $fell(select_pin_n_out.o) && serial_clock_pin_out.oe;
   endsequence
   sequence s_clock_quiet;
      $stable(serial_clock_pin_out.o) [*3];
   endsequence
   sequence s_frame_close;
      $rose(select_pin_n_out.o) && serial_clock_pin_out.oe;
   endsequence
   a_irq_from_flags:
   assert property (irq_out == ((ctrl_out.rx_fault_irq_enable & (status_out.rx_full_flag | status_out.mode_fault_flag))
      | (ctrl_out.tx_irq_enable & status_out.tx_buffer_empty_flag))) else $error("irq does not follow flags");
   a_fault_drops_ctrl:
   assert property ($rose(status_out.mode_fault_flag) |-> !ctrl_out.controller_select_bit
      && !serial_clock_pin_out.oe && !mosi_pin_out.oe) else $error("fault left controller drivers on");
   a_fault_needs_cfg:
   assert property ($rose(status_out.mode_fault_flag) |-> $past(ctrl_out.controller_select_bit)
      && $past(fault_detect_enable_in) && !$past(ctrl_out.select_output_enable)) else $error("fault while not armed");
   a_fault_clear_seq:
   assert property ($fell(status_out.mode_fault_flag) |-> $past(ctrl1_write_in)) else $error("fault flag fell alone");
   a_rx_clear_seq:
   assert property ($fell(status_out.rx_full_flag) |-> $past(data_read_in)) else $error("rx full fell alone");
   a_tx_empty_write:
   assert property ($fell(status_out.tx_buffer_empty_flag) |-> $past(data_write_in)) else $error("tx empty fell alone");
   a_frame_edges:
   assert property (s_frame_close |-> edge_cnt == SSE_EDGE_LAST) else $error("frame edge count wrong");
   a_select_lead:
   assert property (s_frame_open |-> s_clock_quiet) else $error("clock moved with select");
   a_rx_full_end:
   assert property (s_frame_close |-> ##[0:2] status_out.rx_full_flag) else $error("rx full missing at frame end");
   a_sck_idle_level:
   assert property (!busy_out && !$past(busy_out) && $stable(ctrl_out.cpol) && serial_clock_pin_out.oe
      && $past(serial_clock_pin_out.oe) |-> serial_clock_pin_out.o == ctrl_out.cpol) else $error("idle clock level");
endmodule
bind sse_engine sse_engine_properties #(.HALF_DIV(HALF_DIV)) chk_u (.core_clk_in(core_clk_in),
   .reset_in(reset_in), .ctrl1_write_in(ctrl1_write_in), .fault_detect_enable_in(fault_detect_enable_in),
   .data_write_in(data_write_in), .data_read_in(data_read_in), .status_out(status_out), .ctrl_out(ctrl_out),
   .irq_out(irq_out), .busy_out(busy_out), .serial_clock_pin_out(serial_clock_pin_out),
   .mosi_pin_out(mosi_pin_out), .select_pin_n_out(select_pin_n_out));

// >>> test/sse_remote_periph.sv
// Behavioural remote peripheral that answers the engine while it is the controller.
`timescale 1ns/1ps
module sse_remote_periph (
   input wire logic sck_in,
   input wire logic sel_n_in,
   input wire logic mosi_in,
   input wire logic cpol_in,
   input wire logic cpha_in,
   input wire logic lsb_in,
   input wire logic [7:0] reply_in,
   output logic miso_out,
   output logic [7:0] rx_out,
   output logic [7:0] frames_out
);
   logic [7:0] tx;
   int cnt;
   initial begin
      miso_out = 1'b0;
      rx_out = 8'h00;
      frames_out = 8'h00;
      tx = 8'h00;
      cnt = 0;
   end
   // Each frame answers with a different byte, so a dropped or repeated frame is visible.
   always @(negedge sel_n_in) begin
      tx = reply_in + frames_out;
      frames_out = frames_out + 8'h01;
      cnt = 0;
      if (!cpha_in) begin
         miso_out = lsb_in ? tx[0] : tx[7];
         cnt = 1;
      end
   end
   always @(posedge sel_n_in) miso_out = ~miso_out;
   always @(sck_in) if (!sel_n_in) begin
      if ((sck_in != cpol_in) != cpha_in)
         rx_out = lsb_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
      else if (cnt < 8) begin
         miso_out = lsb_in ? tx[cnt] : tx[7-cnt];
         cnt = cnt + 1;
      end
   end
endmodule

// >>> test/tb.sv
// Self-checking bench: engine against a remote peripheral model and a bench-played remote controller.
`timescale 1ns/1ps
module tb;
   import sse_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr_c = 1'b0;
   sse_ctrl_s c_in = SSE_CTRL_RESET;
   logic fde = 1'b0;
   logic rd_s = 1'b0;
   logic wr_d = 1'b0;
   logic [7:0] d_in = 8'h00;
   logic rd_d = 1'b0;
   logic sck_b = 1'b0;
   logic mosi_b = 1'b0;
   logic sel_b = 1'b1;
   logic [7:0] reply = 8'h3c;
   logic irq;
   logic busy;
   logic miso_p;
   logic [7:0] dout;
   logic [7:0] p_rx;
   logic [7:0] p_fr;
   sse_status_s st;
   sse_ctrl_s cr;
   sse_pin_s sck_o;
   sse_pin_s mosi_o;
   sse_pin_s miso_o;
   sse_pin_s sel_o;
   int bad_count = 0;
   int tests_run = 0;
   wire logic sck_w = sck_o.oe ? sck_o.o : sck_b;
   wire logic mosi_w = mosi_o.oe ? mosi_o.o : mosi_b;
   wire logic miso_w = miso_o.oe ? miso_o.o : miso_p;
   wire logic sel_w = sel_o.oe ? sel_o.o : sel_b;
   always #25 clk = ~clk;
   sse_engine #(.HALF_DIV(16'h0004)) dut_u (.core_clk_in(clk), .reset_in(rst), .ctrl1_write_in(wr_c),
      .ctrl1_in(c_in), .fault_detect_enable_in(fde), .status_read_in(rd_s), .status_out(st),
      .data_write_in(wr_d), .data_in(d_in), .data_read_in(rd_d), .data_out(dout), .ctrl_out(cr),
      .irq_out(irq), .busy_out(busy), .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
      .mosi_pin_in(mosi_w), .mosi_pin_out(mosi_o), .miso_pin_in(miso_w), .miso_pin_out(miso_o),
      .select_pin_n_in(sel_w), .select_pin_n_out(sel_o));
   sse_remote_periph rp_u (.sck_in(sck_w), .sel_n_in(sel_w), .mosi_in(mosi_w), .cpol_in(cr.cpol),
      .cpha_in(cr.cpha), .lsb_in(cr.lsb_first_enable), .reply_in(reply), .miso_out(miso_p),
      .rx_out(p_rx), .frames_out(p_fr));
   ////////////////////////////////////////////////////////////////////////////
   task chk_bit(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask
   task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task st_rd;
      @(posedge clk);
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
   endtask
   task cfg(input sse_ctrl_s c);
      @(posedge clk);
      wr_c <= 1'b1;
      c_in <= c;
      @(posedge clk);
      wr_c <= 1'b0;
   endtask
   task dat_wr(input logic [7:0] b);
      st_rd();
      @(posedge clk);
      wr_d <= 1'b1;
      d_in <= b;
      @(posedge clk);
      wr_d <= 1'b0;
   endtask
   task dat_rd;
      st_rd();
      @(posedge clk);
      rd_d <= 1'b1;
      @(posedge clk);
      rd_d <= 1'b0;
   endtask
   task wait_idle;
      int n;
      n = 0;
      while (n < 400 && !(st.rx_full_flag === 1'b1 && busy === 1'b0)) begin
         @(negedge clk);
         n++;
      end
      chk_bit("transfer done", 1'b1, n < 400);
   endtask
   // The bench plays a remote controller on an 80 ns link clock, polarity zero, MSB first.
   task automatic ext_xfer(input logic [7:0] mo, input logic ph, output logic [7:0] mi);
      mi = 8'h00;
      #10;
      sel_b = 1'b0;
      #200;
      for (int k = 0; k < 8; k++) begin
         if (!ph) mosi_b = mo[7-k];
         #40;
         sck_b = 1'b1;
         if (ph) mosi_b = mo[7-k];
         else mi = {mi[6:0], miso_w};
         #40;
         sck_b = 1'b0;
         if (ph) mi = {mi[6:0], miso_w};
      end
      #40;
      sel_b = 1'b1;
      mosi_b = ~mosi_b;
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #500000;
      bad_count++;
      summarize();
   end
   initial begin
      sse_ctrl_s c;
      logic [7:0] b;
      logic [7:0] mi;
      logic [7:0] fr;
      int i;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      fde <= 1'b1;
      @(negedge clk);
      chk_byte("status reset", 8'h01, {5'h00, st});
      chk_byte("ctrl reset", 8'h00, {1'b0, cr});
      for (i = 0; i < 8; i++) begin
         c = {3'b001, i[2], i[1], 1'b1, i[0]};
         cfg(c);
         fr = p_fr;
         b = 8'h95 ^ {i[3:0], 4'h6};
         dat_wr(b);
         wait_idle();
         chk_byte("rx data", reply + fr, dout);
         chk_byte("remote rx", b, p_rx);
         dat_rd();
         @(negedge clk);
         chk_bit("rx full clear", 1'b0, st.rx_full_flag);
      end
      fr = p_fr;
      dat_wr(8'h5a);
      repeat (3) @(negedge clk);
      dat_wr(8'hc3);
      @(negedge clk);
      chk_bit("tx empty queued", 1'b0, st.tx_buffer_empty_flag);
      dat_wr(8'h77);
      wait_idle();
      chk_byte("first rx", reply + fr, dout);
      repeat (3) @(negedge clk);
      wait_idle();
      chk_byte("overrun rx", reply + fr, dout);
      chk_byte("frames", fr + 8'h02, p_fr);
      chk_byte("remote last", 8'hc3, p_rx);
      dat_rd();
      cfg(7'h20);
      @(negedge clk);
      chk_bit("tx irq", 1'b1, irq);
      cfg(7'h50);
      @(negedge clk);
      chk_bit("irq masked", 1'b0, irq);
      @(posedge clk);
      sel_b <= 1'b0;
      for (i = 0; i < 20 && st.mode_fault_flag !== 1'b1; i++) @(negedge clk);
      chk_bit("fault flag", 1'b1, st.mode_fault_flag);
      chk_bit("fault mode", 1'b0, cr.controller_select_bit);
      chk_bit("fault sck oe", 1'b0, sck_o.oe);
      chk_bit("fault mosi oe", 1'b0, mosi_o.oe);
      chk_bit("fault miso oe", 1'b0, miso_o.oe);
      chk_bit("fault irq", 1'b1, irq);
      @(posedge clk);
      sel_b <= 1'b1;
      repeat (4) @(negedge clk);
      cfg(7'h50);
      @(negedge clk);
      chk_bit("fault kept", 1'b1, st.mode_fault_flag);
      st_rd();
      cfg(7'h00);
      @(negedge clk);
      chk_bit("fault clear", 1'b0, st.mode_fault_flag);
      for (i = 0; i < 2; i++) begin
         cfg({4'h0, i[0], 2'b00});
         b = 8'hb4 ^ i[7:0];
         dat_wr(8'h69 ^ i[7:0]);
         ext_xfer(b, i[0], mi);
         wait_idle();
         chk_byte("periph rx", b, dout);
         chk_byte("periph tx", 8'h69 ^ i[7:0], mi);
         dat_rd();
      end
      summarize();
   end
endmodule
